// ==== pbcs_det.sv ====
/*
 pbcs_det: frequency window comparator with enter/exit hysteresis.
 assumes: ref_tick and fb_tick are one-cycle pulses in mclk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module pbcs_det
#(
   parameter int WIN = pbcs_pkg::PBCS_WIN_LEN
)
(
   input  wire logic            mclk,
   input  wire logic            rst_b,
   input  wire logic            run,
   input  wire logic            ref_tick,
   input  wire logic            fb_tick,
   output pbcs_pkg::pbcs_det_t  det
);
   import pbcs_pkg::*;

   logic [7:0] ref_cnt_r;
   logic [7:0] fb_cnt_r;
   logic [7:0] diff;
   pbcs_det_t  det_r;

   function automatic logic [7:0] absdiff(input logic [7:0] a,
                                          input logic [7:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction

   assign diff = absdiff(fb_cnt_r, 8'(WIN));
   assign det  = det_r;

   // =======================================================
   // window counters
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ref_cnt_r <= 8'h00;
         fb_cnt_r  <= 8'h00;
      end
      else if (!run || (ref_tick && ref_cnt_r == 8'(WIN - 1)))
      begin
         ref_cnt_r <= 8'h00;
         fb_cnt_r  <= 8'h00;
      end
      else
      begin
         ref_cnt_r <= ref_cnt_r + {7'h00, ref_tick};
         fb_cnt_r  <= fb_cnt_r + {7'h00, fb_tick};
      end
   end

   // =======================================================
   // hysteresis verdicts at window end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         det_r <= '0;
      else if (!run)
         det_r <= '0;
      else if (ref_tick && ref_cnt_r == 8'(WIN - 1))
      begin
         if (diff <= PBCS_LOCK_TOL)
            det_r.lock <= 1'b1; // RULE_26
         else if (diff > PBCS_UNL_TOL)
            det_r.lock <= 1'b0; // RULE_26
         if (diff <= PBCS_TRK_TOL)
            det_r.track <= 1'b1; // RULE_26
         else if (diff > PBCS_UNT_TOL)
            det_r.track <= 1'b0; // RULE_26
      end
   end
endmodule // pbcs_det
`default_nettype wire

// ==== pbcs_pkg.sv ====
/*
 pbcs_pkg: constants and carrier types for the pll bandwidth and base
 clock select block.
 assumes: one clock mclk, everything synchronous to it.
*/
`default_nettype none
package pbcs_pkg;
   // =======================================================
   // register offsets (byte addresses on the plain port)
   localparam logic [7:0] PBCS_CTRL_ADDR   = 8'h1C;
   localparam logic [7:0] PBCS_BW_ADDR     = 8'h1D;
   localparam logic [7:0] PBCS_PROG_ADDR   = 8'h1E;
   // =======================================================
   // field positions
   localparam int PBCS_IE_BIT    = 7;
   localparam int PBCS_FLAG_BIT  = 6;
   localparam int PBCS_ON_BIT    = 5;
   localparam int PBCS_BCS_BIT   = 4;
   localparam int PBCS_AUTO_BIT  = 7;
   localparam int PBCS_LOCK_BIT  = 6;
   localparam int PBCS_TRK_BIT   = 5;
   // =======================================================
   // reset values
   localparam logic [3:0] PBCS_MUL_RST   = 4'h6;
   localparam logic [3:0] PBCS_RNG_RST   = 4'h6;
   localparam logic [3:0] PBCS_CTRL_LOW  = 4'hF;
   // =======================================================
   // detector windows and hysteresis thresholds, in feedback counts
   localparam int         PBCS_WIN_LEN    = 16;
   localparam logic [7:0] PBCS_LOCK_TOL   = 8'h01;
   localparam logic [7:0] PBCS_UNL_TOL    = 8'h03;
   localparam logic [7:0] PBCS_TRK_TOL   = 8'h02;
   localparam logic [7:0] PBCS_UNT_TOL    = 8'h04;
   // switch-over settle, three cycles of each clock
   localparam int         PBCS_SW_CYC     = 3;
   // nominal range centre, kHz
   localparam int         PBCS_FNOM_KHZ   = 4915;

   typedef struct packed {
      logic       lock_irq_enable;
      logic       pll_enable;
      logic       base_clk_select;
      logic       auto_bw_select;
      logic       track_mode_flag;
   } pbcs_ctrl_t;

   typedef struct packed {
      logic       lock;
      logic       track;
   } pbcs_det_t;
endpackage : pbcs_pkg
`default_nettype wire

// ==== pbcs_sel.sv ====
/*
 pbcs_sel: glitch-free base clock selector and divide by two.
 assumes: xtal_tick and vco_tick are one-cycle samples of each clock
 edge taken in the mclk domain; the output is a level toggled on the
 selected source's edges.
*/
`timescale 1ns/1ns
`default_nettype none
module pbcs_sel
(
   input  wire logic   mclk,
   input  wire logic   rst_b,
   input  wire logic   sel_vco,
   input  wire logic   xtal_tick,
   input  wire logic   vco_tick,
   output logic        base_out,
   output logic        busy
);
   import pbcs_pkg::*;

   typedef enum logic [1:0] {PBCS_RUN, PBCS_WAITX, PBCS_WAITV} pbcs_sw_t;
   pbcs_sw_t   st_r;
   logic       cur_r;
   logic [1:0] cnt_r;
   logic       tick;

   assign tick = cur_r ? vco_tick : xtal_tick;
   assign busy = (st_r != PBCS_RUN);

   // =======================================================
   // transition control: settle on crystal, then on vco when selecting it
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r  <= PBCS_RUN;
         cur_r <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         case (st_r)
            PBCS_RUN:
               if (sel_vco != cur_r)
               begin
                  st_r  <= PBCS_WAITX;
                  cnt_r <= 2'h0;
               end
            PBCS_WAITX:
               if (xtal_tick)
               begin
                  if (cnt_r == 2'(PBCS_SW_CYC - 1))
                  begin
                     st_r  <= PBCS_WAITV;
                     cnt_r <= 2'h0;
                  end
                  else
                     cnt_r <= cnt_r + 2'h1; // RULE_15
               end
            PBCS_WAITV:
               if (vco_tick || !sel_vco)
               begin
                  if (cnt_r == 2'(PBCS_SW_CYC - 1) || !sel_vco)
                  begin
                     st_r  <= PBCS_RUN;
                     cur_r <= sel_vco;
                  end
                  else
                     cnt_r <= cnt_r + 2'h1; // RULE_15
               end
            default:
               st_r <= PBCS_RUN;
         endcase
      end
   end

   // =======================================================
   // output held static during switch, halved otherwise
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         base_out <= 1'b0;
      else if (st_r == PBCS_RUN && tick)
         base_out <= ~base_out; // RULE_16
   end

   hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      busy |=> $stable(base_out)) // RULE_15
      else $error("base clock moved during switch");
endmodule // pbcs_sel
`default_nettype wire

// ==== pbcs_sim_model.sv ====
/*
 pbcs_sim_model: crystal and vco sources plus the bus clock side that
 counts base clock rises.
 assumes: mclk outruns both sources; ticks are one cycle wide.
*/
`timescale 1ns/1ns
`default_nettype none
module pbcs_sim_model
#(
   parameter int XPER = 16
)
(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       pll_run,
   input  wire logic [3:0] mul_n,
   input  wire logic       vco_dead,
   input  wire logic       base_clock_out,
   output logic            xtal_tick,
   output logic            vco_tick,
   output int              rise_cnt
);
   int   xc;
   int   vc;
   int   vper;
   logic base_d;
   // ==============================================
   // sources: vco sits at n times crystal, n of 0 as 1
   assign vper = (mul_n == 4'h0) ? XPER : XPER / int'(mul_n);
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         xc <= 0;
         vc <= 0;
         xtal_tick <= 1'b0;
         vco_tick <= 1'b0;
      end
      else
      begin
         xc <= (xc >= XPER - 1) ? 0 : xc + 1;
         xtal_tick <= (xc == 0);
         // a stopped or dead vco gives no edges at all
         vc <= (vc >= vper - 1) ? 0 : vc + 1;
         vco_tick <= (vc == 0) && pll_run && !vco_dead;
      end
   end
   // ==============================================
   // bus clock side
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         base_d <= 1'b0;
         rise_cnt <= 0;
      end
      else
      begin
         base_d <= base_clock_out;
         if (base_clock_out && !base_d)
            rise_cnt <= rise_cnt + 1;
      end
   end
endmodule // pbcs_sim_model
`default_nettype wire

// ==== pbcs_tb_top.sv ====
/*
 pbcs_tb_top: register-level tests of the clock control block.
 assumes: crystal tick every 16 mclk cycles from the source model.
*/
`timescale 1ns/1ns
`default_nettype none
module pbcs_tb_top;
   import pbcs_pkg::*;
   localparam logic [7:0] CA = PBCS_CTRL_ADDR;
   localparam logic [7:0] BA = PBCS_BW_ADDR;
   localparam logic [7:0] PA = PBCS_PROG_ADDR;
   localparam int         T_WAIT = 50;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic        vco_dead = 1'b0;
   logic [7:0]  rdata;
   logic        xtal_tick;
   logic        vco_tick;
   logic        base_clock_out;
   logic        lock_irq;
   logic        pll_run;
   logic        filter_track;
   logic [3:0]  mul_n;
   logic [3:0]  range_field;
   logic [15:0] centre_khz;
   logic [15:0] d;
   int          rise_cnt;
   int          errors = 0;
   int          check_count = 0;
   always #50 mclk = ~mclk;
   pbcs_top dut_u (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .xtal_tick(xtal_tick), .vco_tick(vco_tick),
      .base_clock_out(base_clock_out), .lock_irq(lock_irq),
      .pll_run(pll_run), .filter_track(filter_track), .mul_n(mul_n),
      .range_field(range_field), .centre_khz(centre_khz));
   pbcs_sim_model far_u (.mclk(mclk), .rst_b(rst_b), .pll_run(pll_run),
      .mul_n(mul_n), .vco_dead(vco_dead), .base_clock_out(base_clock_out),
      .xtal_tick(xtal_tick), .vco_tick(vco_tick), .rise_cnt(rise_cnt));
   // ==============================================
   // tasks
   task automatic check(input string w, input logic [15:0] s,
                        input logic [15:0] e);
      check_count++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      @(posedge mclk);
      d = {8'h00, rdata};
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      rd(a);
      check("reg", d, e);
   endtask
   // polling is bounded so a dead detector cannot hang the run
   task automatic wait_lock(input logic want);
      int i;
      rd(BA);
      for (i = 0; i < 1500 && d[PBCS_LOCK_BIT] !== want; i++)
         rd(BA);
      // flag trails the indicator by one register, interrupt by two
      repeat (2) @(posedge mclk);
      check("lock", 16'(d[PBCS_LOCK_BIT]), 16'(want));
   endtask
   task automatic rises(input int lo, input int hi);
      int c;
      repeat (100) @(posedge mclk);
      c = rise_cnt;
      repeat (320) @(posedge mclk);
      c = rise_cnt - c;
      check("rises", 16'(c >= lo && c <= hi), 16'h0001);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==============================================
   // watchdog, well past the longest polling run
   initial
   begin
      #(100 * 40000);
      errors++;
      conclude();
   end
   // ==============================================
   // tests
   initial
   begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      rdc(CA, 16'h002F);
      rdc(BA, 16'h0000);
      rdc(PA, 16'h0066);
      rises(9, 11);
      $display("test reset done");
      wr(PA, 8'h12);
      rdc(PA, 16'h0066);
      wr(CA, 8'h00);
      rdc(CA, 16'h000F);
      wr(PA, 8'h23);
      rdc(PA, 16'h0023);
      check("mul", 16'(mul_n), 16'h0002);
      check("range", 16'(range_field), 16'h0003);
      check("centre", centre_khz, 16'(3 * PBCS_FNOM_KHZ));
      wr(PA, 8'h20);
      wr(CA, 8'h20);
      wr(CA, 8'h30);
      rdc(CA, 16'h002F);
      check("run", 16'(pll_run), 16'h0000);
      wr(CA, 8'h00);
      wr(CA, 8'h30);
      rdc(CA, 16'h002F);
      $display("test program done");
      wr(CA, 8'h00);
      wr(PA, 8'h22);
      wr(CA, 8'h20);
      repeat (T_WAIT) @(posedge mclk);
      wr(BA, 8'h20);
      rdc(BA, 16'h0020);
      check("track", 16'(filter_track), 16'h0001);
      wr(CA, 8'hA0);
      rdc(CA, 16'h002F);
      check("irq", 16'(lock_irq), 16'h0000);
      repeat (T_WAIT) @(posedge mclk);
      wr(CA, 8'h30);
      rdc(CA, 16'h003F);
      rises(19, 21);
      wr(CA, 8'h10);
      rdc(CA, 16'h003F);
      wr(CA, 8'h20);
      rdc(CA, 16'h002F);
      rises(9, 11);
      $display("test manual done");
      wr(CA, 8'h00);
      wr(BA, 8'h00);
      wr(PA, 8'h02);
      wr(BA, 8'h80);
      wr(CA, 8'hA0);
      wait_lock(1'b1);
      check("bw", 16'(d[7:5]), 16'h0007);
      check("irq", 16'(lock_irq), 16'h0001);
      rdc(CA, 16'h00EF);
      rdc(CA, 16'h00AF);
      check("irq", 16'(lock_irq), 16'h0000);
      wr(BA, 8'h80);
      rd(BA);
      check("bw", 16'(d[7:5]), 16'h0007);
      wr(CA, 8'hB0);
      rdc(CA, 16'h00BF);
      vco_dead <= 1'b1;
      wait_lock(1'b0);
      check("irq", 16'(lock_irq), 16'h0001);
      rd(CA);
      check("flag", 16'(d[PBCS_FLAG_BIT]), 16'h0001);
      repeat (600) @(posedge mclk);
      rd(BA);
      check("track", 16'(d[PBCS_TRK_BIT]), 16'h0000);
      $display("test auto done");
      conclude();
   end
endmodule // pbcs_tb_top
`default_nettype wire

// ==== pbcs_top.sv ====
/*
 pbcs_top: control logic of a pll clock generator: bandwidth mode,
 lock/track indicators, lock interrupt, multiplier/range programming
 and the base clock selector.
 assumes: plain register port synchronous to mclk; crystal and vco
 edges arrive as one-cycle ticks already in the mclk domain.
*/
// Design decisions made here: the strobed register port and the address map.
// How it works
// RULE_01: auto mode lets the lock detector switch acquisition and tracking.
// RULE_02: in auto mode the track flag is read-only and shows filter mode.
// RULE_03: track flag sets inside track tolerance, clears outside untrack one.
// RULE_04: lock indicator sets inside lock tolerance, clears outside unlock.
// RULE_05: with irq enable, each lock toggle raises an interrupt.
// RULE_06: in manual mode the track flag is written and forces the filter.
// RULE_07: software clears the track flag before turning the pll on.
// RULE_08: software waits acquisition time before selecting tracking.
// RULE_09: software waits lock time before selecting the vco clock.
// RULE_10: manual mode hides the lock indicator and blocks interrupts.
// RULE_11: upper program nibble is multiplier n.
// RULE_12: lower program nibble is range factor l.
// RULE_13: n of zero acts as one.
// RULE_14: l of zero disables pll and forces crystal as base clock.
// RULE_15: switch waits three cycles of each clock, output held still; a switch back to crystal waits only three crystal cycles.
// RULE_16: selected clock is halved to a 50 percent base clock.
// RULE_17: vco clock cannot be selected while the pll is off.
// RULE_18: pll cannot be turned off while the vco clock is selected.
// RULE_19: one write cannot change both pll enable and clock select.
// RULE_20: vco centre is l times nominal frequency.
// RULE_21: software selects vco only once lock is shown.
// RULE_22: lock toggle sets change flag; control read clears; manual reads 0.
// RULE_23: select forced 0 while pll off or range zero; enable held by select.
// RULE_24: program register is read-only while the pll is on.
// RULE_25: reset sets pll enable and clears the other control bits.
// RULE_26: detectors compare feedback against reference with hysteresis.
// RULE_27: lock and flag are registered in bus clock domain before use.
`timescale 1ns/1ns
`default_nettype none
module pbcs_top
#(
   parameter int WIN = pbcs_pkg::PBCS_WIN_LEN
)
(
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [7:0]   addr,
   input  wire logic [7:0]   wdata,
   input  wire logic         wr_stb,
   input  wire logic         rd_stb,
   output logic [7:0]        rdata,
   input  wire logic         xtal_tick,
   input  wire logic         vco_tick,
   output logic              base_clock_out,
   output logic              lock_irq,
   output logic              pll_run,
   output logic              filter_track,
   output logic [3:0]        mul_n,
   output logic [3:0]        range_field,
   output logic [15:0]       centre_khz
);
   import pbcs_pkg::*;

   pbcs_ctrl_t ctrl_r;
   pbcs_det_t  det;
   logic       manual_trk_r;
   logic       lock_r;
   logic       lock_d_r;
   logic       lock_change_flag_r;
   logic [3:0] mul_r;
   logic [3:0] rng_r;
   logic       fb_tick_r;
   logic [3:0] fb_div_r;
   logic [3:0] n_eff;
   logic       run;
   logic       base_w;
   logic       sel_busy;
   logic       wr_ctrl;
   logic       rd_ctrl;
   logic       toggle;
   logic [7:0] rd_nxt;

   function automatic logic [3:0] eff_mul(input logic [3:0] n);
      eff_mul = (n == 4'h0) ? 4'h1 : n; // RULE_13
   endfunction

   assign n_eff   = eff_mul(mul_r);
   assign run     = ctrl_r.pll_enable && (rng_r != 4'h0); // RULE_14
   assign wr_ctrl = wr_stb && addr == PBCS_CTRL_ADDR;
   assign rd_ctrl = rd_stb && addr == PBCS_CTRL_ADDR;
   assign toggle  = ctrl_r.auto_bw_select && (lock_r != lock_d_r);

   // =======================================================
   // feedback divider: vco ticks divided by n
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fb_div_r  <= 4'h0;
         fb_tick_r <= 1'b0;
      end
      else
      begin
         fb_tick_r <= 1'b0;
         if (!run)
            fb_div_r <= 4'h0;
         else if (vco_tick)
         begin
            if (fb_div_r >= n_eff - 4'h1)
            begin
               fb_div_r  <= 4'h0;
               fb_tick_r <= 1'b1; // RULE_11
            end
            else
               fb_div_r <= fb_div_r + 4'h1;
         end
      end
   end

   pbcs_det #(.WIN(WIN)) u_det
   (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .run      (run),
      .ref_tick (xtal_tick),
      .fb_tick  (fb_tick_r),
      .det      (det)
   );

   // =======================================================
   // control register, pll enable / select interlock
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_r       <= '0;
         ctrl_r.pll_enable <= 1'b1; // RULE_25
         manual_trk_r <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            if (ctrl_r.auto_bw_select)
               ctrl_r.lock_irq_enable <= wdata[PBCS_IE_BIT];
            if (wdata[PBCS_ON_BIT] != ctrl_r.pll_enable)
            begin
               if (!ctrl_r.base_clk_select)
                  ctrl_r.pll_enable <= wdata[PBCS_ON_BIT]; // RULE_18
            end
            else if (ctrl_r.pll_enable && rng_r != 4'h0) // RULE_23
               ctrl_r.base_clk_select <= wdata[PBCS_BCS_BIT]; // RULE_19
         end
         if (!run)
            ctrl_r.base_clk_select <= 1'b0; // RULE_17
         if (wr_stb && addr == PBCS_BW_ADDR)
         begin
            ctrl_r.auto_bw_select <= wdata[PBCS_AUTO_BIT];
            if (!wdata[PBCS_AUTO_BIT])
               ctrl_r.lock_irq_enable <= 1'b0;
            if (!ctrl_r.auto_bw_select)
               manual_trk_r <= wdata[PBCS_TRK_BIT]; // RULE_06
         end
         // auto mode follows the detector, manual mode the stored bit
         if (ctrl_r.auto_bw_select) // RULE_01
            ctrl_r.track_mode_flag <= det.track; // RULE_03
         else
            ctrl_r.track_mode_flag <= manual_trk_r; // RULE_06
      end
   end

   // =======================================================
   // lock indicator, registered into the bus side
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lock_r   <= 1'b0;
         lock_d_r <= 1'b0;
      end
      else
      begin
         // manual mode holds the indicator low, so it never toggles
         lock_r   <= ctrl_r.auto_bw_select && det.lock; // RULE_04
         lock_d_r <= lock_r; // RULE_27
      end
   end

   // =======================================================
   // lock change flag: a toggle beats a clearing read
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         lock_change_flag_r <= 1'b0;
      else if (toggle)
         lock_change_flag_r <= 1'b1; // RULE_22
      else if (rd_ctrl || !ctrl_r.auto_bw_select)
         lock_change_flag_r <= 1'b0; // RULE_22
   end

   // =======================================================
   // interrupt request, stands until the flag is read away
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         lock_irq <= 1'b0;
      else
         lock_irq <= ctrl_r.auto_bw_select // RULE_10
                     && ctrl_r.lock_irq_enable
                     && lock_change_flag_r; // RULE_05
   end

   // =======================================================
   // program register, frozen while the pll is on
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mul_r <= PBCS_MUL_RST;
         rng_r <= PBCS_RNG_RST;
      end
      else if (wr_stb && addr == PBCS_PROG_ADDR)
      begin
         // a running loop must not see its divider move underneath it
         if (!ctrl_r.pll_enable) // RULE_24
         begin
            mul_r <= wdata[7:4]; // RULE_11
            rng_r <= wdata[3:0]; // RULE_12
         end
      end
   end

   // =======================================================
   // read data, presented one cycle after the strobe
   always_comb
   begin
      rd_nxt = 8'h00;
      if (addr == PBCS_CTRL_ADDR)
         rd_nxt = {ctrl_r.lock_irq_enable,
                   lock_change_flag_r && ctrl_r.auto_bw_select,
                   ctrl_r.pll_enable,
                   ctrl_r.base_clk_select,
                   PBCS_CTRL_LOW}; // RULE_22
      else if (addr == PBCS_BW_ADDR)
         rd_nxt = {ctrl_r.auto_bw_select,
                   lock_r,
                   ctrl_r.track_mode_flag, // RULE_02
                   5'h00};
      else if (addr == PBCS_PROG_ADDR)
         rd_nxt = {mul_r, rng_r};
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rdata <= 8'h00;
      else if (rd_stb)
         rdata <= rd_nxt;
      else
         rdata <= 8'h00;
   end

   // =======================================================
   // status outputs, each from its own flip-flop
   // centre_khz wraps for range factors above 13: kept 16 bits wide
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pll_run     <= 1'b1;
         mul_n       <= PBCS_MUL_RST;
         range_field <= PBCS_RNG_RST;
         centre_khz  <= 16'(PBCS_RNG_RST * PBCS_FNOM_KHZ);
      end
      else
      begin
         pll_run     <= run; // RULE_14
         mul_n       <= mul_r; // RULE_11
         range_field <= rng_r; // RULE_12
         centre_khz  <= 16'(rng_r * PBCS_FNOM_KHZ); // RULE_20
      end
   end

   assign filter_track   = ctrl_r.track_mode_flag; // RULE_06
   assign base_clock_out = base_w;

   // =======================================================
   // base clock selector
   pbcs_sel u_sel
   (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .sel_vco   (ctrl_r.base_clk_select), // RULE_15
      .xtal_tick (xtal_tick),
      .vco_tick  (vco_tick),
      .base_out  (base_w), // RULE_16
      .busy      (sel_busy)
   );

   // =======================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sel_guard_a: assert property (ctrl_r.base_clk_select // RULE_18
      |-> ctrl_r.pll_enable)
      else $error("vco selected while pll enable low");

   sel_run_a: assert property (ctrl_r.base_clk_select // RULE_17
      |-> run)
      else $error("vco selected while loop not running");

   prog_frozen_a: assert property (ctrl_r.pll_enable // RULE_24
      && wr_stb && addr == PBCS_PROG_ADDR |=> $stable({mul_r, rng_r}))
      else $error("program register moved while pll on");

   one_change_a: assert property (wr_ctrl // RULE_19
      && wdata[PBCS_ON_BIT] != ctrl_r.pll_enable
      |=> $stable(ctrl_r.base_clk_select))
      else $error("enable and select changed by one write");

   flag_set_a: assert property (toggle // RULE_22
      |=> lock_change_flag_r)
      else $error("lock toggle did not set change flag");

   irq_quiet_a: assert property (!ctrl_r.auto_bw_select // RULE_10
      |=> !lock_irq && !lock_r)
      else $error("manual mode showed lock or interrupt");

   irq_raise_a: assert property (ctrl_r.auto_bw_select // RULE_05
      && ctrl_r.lock_irq_enable && lock_change_flag_r |=> lock_irq)
      else $error("enabled lock change gave no interrupt");

   track_auto_a: assert property (ctrl_r.auto_bw_select // RULE_03
      |=> ctrl_r.track_mode_flag == $past(det.track))
      else $error("auto track flag does not follow detector");

   lock_toggle_c: cover property (toggle);
   switch_start_c: cover property ($rose(sel_busy));
   irq_seen_c: cover property (lock_irq);
   vco_running_c: cover property (ctrl_r.base_clk_select && !sel_busy);
endmodule // pbcs_top
`default_nettype wire
